/* File: hw/bipc_port_ctrl.sv */
// What this block does
// RULE1: Serial out pin is push-pull when mode bit 0, open-drain when 1.
// RULE2: Stop entry clears selections, floats all pins, turns pull-ups off.
// RULE3: Halt signal stays high in every low power mode but stop.
// RULE4: Standby holds latches and outputs; running peripherals keep their pins.
// RULE5: Bit port has six pins, each set and tested singly.
// RULE6: Set-bit instructions write latch 1, clear-bit instructions write 0.
// RULE7: Bit test returns the present level of the addressed pin.
// RULE8: Drive enable 0 floats the pin; 1 drives the latch value.
// RULE9: Low enable bits 3..0 map pins 3..0; high bits 1..0 map pins 5..4.
// RULE10: All output latches go to 1 at reset and stop entry.
// RULE11: Function bit 3 gives pin 4 to the stop-release input.
// RULE12: Function bit 0 gives pin 0 to interrupt zero / timer event.
// RULE13: Peripheral selection overrides drive enable on shared pins.
// RULE14: Software should keep unused pins at reset values or assign peripherals.
// RULE15: Nibble group is three 4-bit ports and one 3-bit port.
// RULE16: Nibble store loads a port's latches; nibble load reads its pins.
// RULE17: Each nibble pin drives its latch when its own enable is 1.
// RULE18: Enables sit in data RAM space; latches only via port instructions.
// RULE19: Open-drain pin with enable: latch 0 pulls low, latch 1 floats.
// RULE20: Global pull-up bit 1 turns on pull-ups where latch is 1; the code leaves them off on open-drain pins.
// RULE21: Writes to unused high enable bits 3 and 2 are dropped.
// RULE22: Writes reach the pins at the end of the writing cycle.
`timescale 1ns/10ps
module bipc_port_ctrl #(
	parameter int BIT_PIN_COUNT = bipc_pkg::BIT_PINS,
	parameter int NIB_COUNT     = bipc_pkg::NIB_PORTS
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire bipc_pkg::bipc_pwr_t     power_mode,
	input  wire logic                    ram_wr,
	input  wire logic [7:0]              ram_addr,
	input  wire logic [3:0]              ram_wdata,
	input  wire bipc_pkg::bipc_op_t      port_op,
	input  wire logic [3:0]              port_sel,
	input  wire logic [3:0]              port_wdata,
	output logic      [3:0]              port_rdata,
	output logic                         test_bit,
	input  wire logic [5:0]              bitport_in,
	output logic      [5:0]              bitport_out,
	output logic      [5:0]              bitport_oe,
	output logic      [5:0]              bitport_pullup,
	input  wire logic [15:0]             nibble_in,
	output logic      [15:0]             nibble_out,
	output logic      [15:0]             nibble_oe,
	output logic      [15:0]             nibble_pullup,
	input  wire logic [15:0]             nibble_open_drain,
	input  wire logic [15:0]             nibble_periph_sel,
	output logic                         stop_release_input,
	output logic                         external_irq_zero,
	output logic                         internal_halt_n
);
	import bipc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [3:0]                 pin_function_select_b_q;
	logic [3:0]                 low_pins_drive_enable_q;
	logic [1:0]                 high_pins_drive_enable_q;
	logic [3:0]                 misc_pin_control_q;
	logic [NIB_WIDTH-1:0]       nibble_port_drive_enable_q [NIB_COUNT];
	logic [BIT_PIN_COUNT-1:0]   pin_output_latch_q;
	logic [BIT_PIN_COUNT-1:0]   pin_output_latch_d;
	logic [3:0]                 port_rdata_q;
	logic                       test_bit_q;
	logic                       stop_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding
	wire logic                  in_stop;
	wire logic                  stop_entry;
	wire logic                  wr_fsel;
	wire logic                  wr_low;
	wire logic                  wr_high;
	wire logic                  wr_misc;
	wire logic                  nib_wr_hit;
	wire logic [1:0]            nib_wr_idx;
	wire logic [2:0]            bit_idx;
	wire logic                  bit_valid;
	wire logic                  nib_store;
	wire logic                  nib_load;
	wire logic [1:0]            nib_idx;
	wire logic [BIT_PIN_COUNT-1:0] bitport_drive_enable;
	wire logic [BIT_PIN_COUNT-1:0] bit_periph;
	wire logic                  serial_out_drive_mode;
	wire logic                  global_pullup_enable;
	wire logic                  stop_release_pin_select;
	wire logic                  irq_event_pin_select;

	function automatic logic addr_hit(input logic wr, input logic [7:0] a, input logic [7:0] target);
		addr_hit = wr & (a == target);
	endfunction : addr_hit

	function automatic logic sel_below(input logic [3:0] sel, input int limit);
		sel_below = (sel < 4'(limit));
	endfunction : sel_below

	assign in_stop         = (power_mode == BIPC_PWR_STOP);
	assign stop_entry      = in_stop & ~stop_prev_q;
	assign internal_halt_n = ~in_stop;                                         // see RULE2 RULE3

	assign wr_fsel    = addr_hit(ram_wr, ram_addr, ADDR_FUNC_SEL_B);           // see RULE18
	assign wr_low     = addr_hit(ram_wr, ram_addr, ADDR_LOW_DRV_EN);           // see RULE18
	assign wr_high    = addr_hit(ram_wr, ram_addr, ADDR_HIGH_DRV_EN);          // see RULE18
	assign wr_misc    = addr_hit(ram_wr, ram_addr, ADDR_MISC_CTRL);
	assign nib_wr_hit = ram_wr & (ram_addr[7:2] == ADDR_NIB_DRV_EN0[7:2]);     // see RULE18
	assign nib_wr_idx = ram_addr[1:0];

	assign bit_idx    = port_sel[2:0];
	assign bit_valid  = sel_below(port_sel, BIT_PIN_COUNT);                    // see RULE5
	assign nib_idx    = port_sel[1:0];
	assign nib_store  = (port_op == BIPC_OP_STORE) & sel_below(port_sel, NIB_COUNT) & ~in_stop;
	assign nib_load   = (port_op == BIPC_OP_LOAD) & sel_below(port_sel, NIB_COUNT);

	assign serial_out_drive_mode   = misc_pin_control_q[MISC_SO_MODE_BIT];
	assign global_pullup_enable    = misc_pin_control_q[MISC_PULLUP_BIT];
	assign stop_release_pin_select = pin_function_select_b_q[FSEL_STOP_BIT];
	assign irq_event_pin_select    = pin_function_select_b_q[FSEL_IRQ_BIT];

	assign bitport_drive_enable = {high_pins_drive_enable_q, low_pins_drive_enable_q};   // see RULE9
	assign bit_periph = {1'b0, stop_release_pin_select, 3'b000, irq_event_pin_select};   // see RULE11 RULE12

	// Peripheral inputs see the pin only while selected; idle high otherwise
	assign stop_release_input = stop_release_pin_select ? bitport_in[4] : 1'b1;          // see RULE11
	assign external_irq_zero  = irq_event_pin_select ? bitport_in[0] : 1'b1;             // see RULE12

	////////////////////////////////////////////////////////////////////////////////
	// Register writes; standby holds everything because the CPU issues none
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_function_select_b_q <= REG_RESET;
			low_pins_drive_enable_q <= REG_RESET;
			high_pins_drive_enable_q <= REG_RESET[1:0];
			misc_pin_control_q <= REG_RESET;
		end else if (stop_entry) begin
			pin_function_select_b_q <= REG_RESET;                                // see RULE2
			low_pins_drive_enable_q <= REG_RESET;
			high_pins_drive_enable_q <= REG_RESET[1:0];
			misc_pin_control_q <= REG_RESET;                                     // see RULE2
		end else begin
			if (wr_fsel)
				pin_function_select_b_q <= ram_wdata;                            // see RULE22
			if (wr_low)
				low_pins_drive_enable_q <= ram_wdata;
			if (wr_high)
				high_pins_drive_enable_q <= ram_wdata[HIGH_DRV_USED-1:0];        // see RULE21
			if (wr_misc)
				misc_pin_control_q <= ram_wdata;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NIB_COUNT; i++)
				nibble_port_drive_enable_q[i] <= REG_RESET;
		end else if (stop_entry) begin
			for (int i = 0; i < NIB_COUNT; i++)
				nibble_port_drive_enable_q[i] <= REG_RESET;
		end else if (nib_wr_hit) begin
			nibble_port_drive_enable_q[nib_wr_idx] <= ram_wdata;                // see RULE17
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit port latches
	always_comb begin
		pin_output_latch_d = pin_output_latch_q;
		if (bit_valid & ~in_stop) begin
			case (port_op)
				BIPC_OP_SET: pin_output_latch_d[bit_idx] = 1'b1;                // see RULE6
				BIPC_OP_CLR: pin_output_latch_d[bit_idx] = 1'b0;                // see RULE6
				default:     pin_output_latch_d = pin_output_latch_q;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			pin_output_latch_q <= {BIT_PIN_COUNT{LATCH_RESET}};                  // see RULE10
		else if (stop_entry)
			pin_output_latch_q <= {BIT_PIN_COUNT{LATCH_RESET}};                  // see RULE10
		else
			pin_output_latch_q <= pin_output_latch_d;                            // see RULE4
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			stop_prev_q <= 1'b0;
		else
			stop_prev_q <= in_stop;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read-back of pin levels
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			test_bit_q   <= 1'b0;
			port_rdata_q <= 4'h0;
		end else begin
			if ((port_op == BIPC_OP_TEST) & bit_valid)
				test_bit_q <= bitport_in[bit_idx];                              // see RULE7
			if (nib_load)
				port_rdata_q <= nibble_in[nib_idx*NIB_WIDTH +: NIB_WIDTH];       // see RULE16
		end
	end

	assign test_bit   = test_bit_q;
	assign port_rdata = port_rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Bit port pin cells
	for (genvar g = 0; g < BIT_PIN_COUNT; g++) begin : g_bit
		bipc_pin_cell u_cell (
			.latch      (pin_output_latch_q[g]),
			.drive_en   (bitport_drive_enable[g]),
			.open_drain (1'b0),
			.periph_sel (bit_periph[g]),
			.halt_n     (internal_halt_n),
			.pullup_en  (global_pullup_enable),
			.pin_out    (bitport_out[g]),
			.pin_oe     (bitport_oe[g]),
			.pullup_on  (bitport_pullup[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Nibble ports, the last one three pins wide
	for (genvar p = 0; p < NIB_COUNT; p++) begin : g_nib
		wire logic [NIB_WIDTH-1:0] latch;
		bipc_nibble_port #(.WIDTH(NIB_WIDTH)) u_port (
			.clk        (clk),
			.reset      (reset),
			.stop_entry (stop_entry),
			.load       (nib_store & (nib_idx == 2'(p))),
			.load_data  (port_wdata),
			.latch_q    (latch)
		);
		for (genvar b = 0; b < NIB_WIDTH; b++) begin : g_pin
			localparam int  IDX    = p*NIB_WIDTH + b;
			localparam bit  EXISTS = !(p == NIB_COUNT-1 && b == 0);            // see RULE15
			wire logic od;
			wire logic oe_raw;
			wire logic pu_raw;
			assign od = (p == NIB_SO_PORT && b == NIB_SO_PIN) ?
				(nibble_open_drain[IDX] | serial_out_drive_mode) : nibble_open_drain[IDX];  // see RULE1
			bipc_pin_cell u_cell (
				.latch      (latch[b]),
				.drive_en   (nibble_port_drive_enable_q[p][b]),                 // see RULE17
				.open_drain (od),
				.periph_sel (nibble_periph_sel[IDX]),
				.halt_n     (internal_halt_n),
				.pullup_en  (global_pullup_enable),
				.pin_out    (nibble_out[IDX]),
				.pin_oe     (oe_raw),
				.pullup_on  (pu_raw)
			);
			assign nibble_oe[IDX] = oe_raw & EXISTS;
			assign nibble_pullup[IDX] = pu_raw & EXISTS;                        // see RULE15
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_halt_stop: assert property (@(posedge clk) disable iff (reset) // see RULE3
		internal_halt_n == !(power_mode == BIPC_PWR_STOP))
		else $error("halt level does not follow stop mode");
	a_stop_float: assert property (@(posedge clk) disable iff (reset) // see RULE2
		in_stop |-> (bitport_oe == 6'h00) && (nibble_oe == 16'h0000) && (bitport_pullup == 6'h00))
		else $error("pin driven during stop");
	a_stop_latch: assert property (@(posedge clk) disable iff (reset) // see RULE10
		stop_entry |=> (pin_output_latch_q == 6'h3F) && (pin_function_select_b_q == 4'h0))
		else $error("stop entry did not restore latches");
	a_set_bit: assert property (@(posedge clk) disable iff (reset) // see RULE6
		(port_op == BIPC_OP_SET) && bit_valid && !in_stop |=> pin_output_latch_q[$past(bit_idx)])
		else $error("set bit did not set latch");
	a_clr_bit: assert property (@(posedge clk) disable iff (reset) // see RULE6
		(port_op == BIPC_OP_CLR) && bit_valid && !in_stop |=> !pin_output_latch_q[$past(bit_idx)])
		else $error("clear bit did not clear latch");
	a_drive_en: assert property (@(posedge clk) disable iff (reset) // see RULE8
		wr_low && !stop_entry && !irq_event_pin_select && !in_stop ##1
		!pin_function_select_b_q[0] && internal_halt_n |-> bitport_oe[0] == $past(ram_wdata[0]))
		else $error("drive enable write not seen on pin");
	a_periph_prio: assert property (@(posedge clk) disable iff (reset) // see RULE13
		stop_release_pin_select |-> !bitport_oe[4] && stop_release_input == bitport_in[4])
		else $error("shared pin still driven");
	a_high_unused: assert property (@(posedge clk) disable iff (reset) // see RULE21
		wr_high && !stop_entry |=> high_pins_drive_enable_q == $past(ram_wdata[1:0]))
		else $error("high enable write wrong");
	a_so_od: assert property (@(posedge clk) disable iff (reset) // see RULE19
		serial_out_drive_mode && nibble_out[2] |-> 1'b0)
		else $error("open-drain serial pin drove high");
	a_oe_low_map: assert property (@(posedge clk) disable iff (reset) // see RULE9
		!in_stop && !bit_periph[1] |-> bitport_oe[1] == low_pins_drive_enable_q[1])
		else $error("low enable bit maps to wrong pin");
	a_oe_high_map: assert property (@(posedge clk) disable iff (reset) // see RULE9
		!in_stop && !bit_periph[5] |-> bitport_oe[5] == high_pins_drive_enable_q[1])
		else $error("high enable bit maps to wrong pin");
	a_drive_out: assert property (@(posedge clk) disable iff (reset) // see RULE8
		bitport_oe[1] |-> bitport_out[1] == pin_output_latch_q[1])
		else $error("driven pin does not show latch");
	a_irq_route: assert property (@(posedge clk) disable iff (reset) // see RULE12
		irq_event_pin_select |-> !bitport_oe[0] && external_irq_zero == bitport_in[0])
		else $error("interrupt pin not routed");
	a_irq_idle: assert property (@(posedge clk) disable iff (reset) // see RULE12
		!irq_event_pin_select |-> external_irq_zero)
		else $error("interrupt input active while deselected");
	a_stop_idle: assert property (@(posedge clk) disable iff (reset) // see RULE11
		!stop_release_pin_select |-> stop_release_input)
		else $error("stop release active while deselected");
	a_pullup_off: assert property (@(posedge clk) disable iff (reset) // see RULE20
		!global_pullup_enable |-> bitport_pullup == 6'h00 && nibble_pullup == 16'h0000)
		else $error("pull-up on while disabled");
	a_pullup_latch: assert property (@(posedge clk) disable iff (reset) // see RULE20
		global_pullup_enable && internal_halt_n |-> bitport_pullup == pin_output_latch_q)
		else $error("pull-up does not follow latch");
	a_pin_missing: assert property (@(posedge clk) disable iff (reset) // see RULE15
		!nibble_oe[(NIB_COUNT-1)*NIB_WIDTH] && !nibble_pullup[(NIB_COUNT-1)*NIB_WIDTH])
		else $error("missing pin of short port active");

	////////////////////////////////////////////////////////////////////////////////
	// Instruction and power mode checks
	a_test_bit: assert property (@(posedge clk) disable iff (reset) // see RULE7
		(port_op == BIPC_OP_TEST) && bit_valid |=> test_bit == $past(bitport_in[bit_idx]))
		else $error("bit test returned wrong level");
	a_nib_load: assert property (@(posedge clk) disable iff (reset) // see RULE16
		nib_load |=> port_rdata == $past(nibble_in[nib_idx*NIB_WIDTH +: NIB_WIDTH]))
		else $error("nibble load returned wrong levels");
	a_stby_hold: assert property (@(posedge clk) disable iff (reset) // see RULE4
		(power_mode == BIPC_PWR_STANDBY) && (port_op == BIPC_OP_NONE) |=> $stable(pin_output_latch_q))
		else $error("latch changed in standby");
	a_stop_hold: assert property (@(posedge clk) disable iff (reset) // see RULE2
		in_stop && !stop_entry |=> $stable(pin_output_latch_q))
		else $error("latch changed in stop");
	a_misc_stop: assert property (@(posedge clk) disable iff (reset) // see RULE2
		stop_entry |=> misc_pin_control_q == REG_RESET && low_pins_drive_enable_q == REG_RESET)
		else $error("stop entry left control bits set");
	a_fsel_write: assert property (@(posedge clk) disable iff (reset) // see RULE22
		wr_fsel && !stop_entry |=> pin_function_select_b_q == $past(ram_wdata))
		else $error("function select write not taken");
	c_stop_entry: cover property (@(posedge clk) disable iff (reset) stop_entry);
	c_nib_store:  cover property (@(posedge clk) disable iff (reset) nib_store);
	c_irq_sel:    cover property (@(posedge clk) disable iff (reset) irq_event_pin_select && !bitport_in[0]);
	c_stby:       cover property (@(posedge clk) disable iff (reset) power_mode == BIPC_PWR_STANDBY);
	c_so_od:      cover property (@(posedge clk) disable iff (reset) serial_out_drive_mode && nibble_oe[2]);

endmodule : bipc_port_ctrl

/* File: hw/bipc_pkg.sv */
package bipc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Data RAM addresses of the port registers
	localparam logic [7:0] ADDR_FUNC_SEL_B   = 8'h24;
	localparam logic [7:0] ADDR_LOW_DRV_EN   = 8'h2C;
	localparam logic [7:0] ADDR_HIGH_DRV_EN  = 8'h2D;
	localparam logic [7:0] ADDR_NIB_DRV_EN0  = 8'h30;
	localparam logic [7:0] ADDR_MISC_CTRL    = 8'h0C;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int         FSEL_STOP_BIT     = 3;
	localparam int         FSEL_IRQ_BIT      = 0;
	localparam int         MISC_SO_MODE_BIT  = 2;
	localparam int         MISC_PULLUP_BIT   = 3;
	localparam int         HIGH_DRV_USED     = 2;
	localparam logic [3:0] REG_RESET         = 4'h0;
	localparam logic       LATCH_RESET       = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Pin groups
	localparam int BIT_PINS    = 6;
	localparam int NIB_PORTS   = 4;
	localparam int NIB_WIDTH   = 4;
	localparam int NIB_SO_PORT = 0;
	localparam int NIB_SO_PIN  = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Port instruction codes
	typedef enum logic [2:0] {
		BIPC_OP_NONE   = 3'h0,
		BIPC_OP_SET    = 3'h1,
		BIPC_OP_CLR    = 3'h2,
		BIPC_OP_STORE  = 3'h3,
		BIPC_OP_LOAD   = 3'h4,
		BIPC_OP_TEST   = 3'h5
	} bipc_op_t;

	// Power state
	typedef enum logic [2:0] {
		BIPC_PWR_RUN     = 3'b001,
		BIPC_PWR_STANDBY = 3'b010,
		BIPC_PWR_STOP    = 3'b100
	} bipc_pwr_t;

endpackage : bipc_pkg

/* File: hw/bipc_pin_cell.sv */
`timescale 1ns/10ps
module bipc_pin_cell (
	input  wire logic latch,
	input  wire logic drive_en,
	input  wire logic open_drain,
	input  wire logic periph_sel,
	input  wire logic halt_n,
	input  wire logic pullup_en,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_on
);
	wire logic own_drive;

	// Peripheral ownership wins over drive enable, halt forces high impedance
	assign own_drive = drive_en & ~periph_sel & halt_n;                       // see RULE8 RULE13 RULE2
	assign pin_out   = open_drain ? 1'b0 : latch;                             // see RULE19
	assign pin_oe    = own_drive & ~(open_drain & latch);                     // see RULE1 RULE19
	assign pullup_on = pullup_en & latch & ~open_drain & halt_n;              // see RULE20 RULE2

endmodule : bipc_pin_cell

/* File: hw/bipc_nibble_port.sv */
`timescale 1ns/10ps
module bipc_nibble_port #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             stop_entry,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_data,
	output logic      [WIDTH-1:0] latch_q
);
	import bipc_pkg::*;

	// Whole-nibble output latch, set to ones at reset and stop entry
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			latch_q <= {WIDTH{LATCH_RESET}};                                  // see RULE10
		else if (stop_entry)
			latch_q <= {WIDTH{LATCH_RESET}};                                  // see RULE10
		else if (load)
			latch_q <= load_data;                                             // see RULE16
	end

endmodule : bipc_nibble_port

/* File: tb/bipc_pin_model.sv */
`timescale 1ns/10ps
module bipc_pin_model #(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] drv_out,
	input  wire logic [W-1:0] drv_oe,
	input  wire logic [W-1:0] pull_en,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	output logic      [W-1:0] pin
);
	logic [W-1:0] last_q;

	////////////////////////////////////////////////////////////////////////////////
	// Board side of the pins; a floating, unpulled line shows the inverse of its last level
	always_ff @(posedge clk) begin
		last_q <= pin;
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (drv_oe[i]) begin
				pin[i] = drv_out[i];
			end else if (ext_en[i]) begin
				pin[i] = ext_val[i];
			end else if (pull_en[i]) begin
				pin[i] = 1'b1;
			end else begin
				pin[i] = ~last_q[i];
			end
		end
	end
endmodule : bipc_pin_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import bipc_pkg::*;
	logic clk, reset, ram_wr, test_bit, stop_release_input, external_irq_zero, internal_halt_n;
	bipc_pwr_t   power_mode;
	bipc_op_t    port_op;
	logic [7:0]  ram_addr;
	logic [3:0]  ram_wdata, port_sel, port_wdata, port_rdata;
	logic [5:0]  bitport_in, bitport_out, bitport_oe, bitport_pullup, bit_ext;
	logic [15:0] nibble_in, nibble_out, nibble_oe, nibble_pullup, nib_ext, nibble_periph_sel;
	int          n_errors, total_checks;

	bipc_port_ctrl bipc_port_ctrl_inst (.clk(clk), .reset(reset), .power_mode(power_mode), .ram_wr(ram_wr),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .port_op(port_op), .port_sel(port_sel),
		.port_wdata(port_wdata), .port_rdata(port_rdata), .test_bit(test_bit), .bitport_in(bitport_in),
		.bitport_out(bitport_out), .bitport_oe(bitport_oe), .bitport_pullup(bitport_pullup),
		.nibble_in(nibble_in), .nibble_out(nibble_out), .nibble_oe(nibble_oe), .nibble_pullup(nibble_pullup),
		.nibble_open_drain(16'h0FF0), .nibble_periph_sel(nibble_periph_sel),
		.stop_release_input(stop_release_input), .external_irq_zero(external_irq_zero),
		.internal_halt_n(internal_halt_n));
	bipc_pin_model #(.W(6)) bit_model_inst (.clk(clk), .drv_out(bitport_out), .drv_oe(bitport_oe),
		.pull_en(bitport_pullup), .ext_val(bit_ext), .ext_en(6'h3F), .pin(bitport_in));
	bipc_pin_model #(.W(16)) nib_model_inst (.clk(clk), .drv_out(nibble_out), .drv_oe(nibble_oe),
		.pull_en(nibble_pullup), .ext_val(nib_ext), .ext_en(16'hFFFF), .pin(nibble_in));

	always #25 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		ram_wr = 1'b1;
		ram_addr = a;
		ram_wdata = d;
		tick();
		ram_wr = 1'b0;
		tick();
	endtask : wr

	task automatic op(input bipc_op_t o, input logic [3:0] s, input logic [3:0] d);
		port_op = o;
		port_sel = s;
		port_wdata = d;
		tick();
		port_op = BIPC_OP_NONE;
		tick();
	endtask : op

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic results();
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_errors++;
		results();
	end

	initial begin
		logic [5:0] exp6;
		clk = 1'b0; reset = 1'b1; power_mode = BIPC_PWR_RUN; ram_wr = 1'b0; ram_addr = 8'h00;
		ram_wdata = 4'h0; port_op = BIPC_OP_NONE; port_sel = 4'h0; port_wdata = 4'h0;
		bit_ext = 6'h29; nib_ext = 16'h0600; nibble_periph_sel = 16'h0000;
		n_errors = 0; total_checks = 0;
		repeat (20) @(posedge clk);
		#1 reset = 1'b0;
		chk("reset oe", 16'h0000, 16'(bitport_oe));
		chk("reset pullup", 16'h0000, 16'(bitport_pullup));
		chk("reset halt", 16'h0001, 16'(internal_halt_n));
		// Enable mapping, unused high bits dropped, latches come up at 1
		wr(ADDR_LOW_DRV_EN, 4'hF);
		wr(ADDR_HIGH_DRV_EN, 4'hC);
		chk("oe low only", 16'h000F, 16'(bitport_oe));
		wr(ADDR_HIGH_DRV_EN, 4'h3);
		chk("oe all", 16'h003F, 16'(bitport_oe));
		chk("latch reset", 16'h003F, 16'(bitport_out));
		// Walk clear then set across all six pins, with an idle cycle after each op
		exp6 = 6'h3F;
		for (int i = 0; i < 6; i++) begin
			op(BIPC_OP_CLR, 4'(i), 4'h0);
			exp6[i] = 1'b0;
			chk("clear bit", 16'(exp6), 16'(bitport_out));
		end
		op(BIPC_OP_SET, 4'h6, 4'h0);
		chk("index 6 ignored", 16'h0000, 16'(bitport_out));
		for (int i = 0; i < 6; i++) begin
			op(BIPC_OP_SET, 4'(i), 4'h0);
			exp6[i] = 1'b1;
			chk("set bit", 16'(exp6), 16'(bitport_out));
		end
		// Bit test reads the board level with drivers off
		wr(ADDR_LOW_DRV_EN, 4'h0);
		wr(ADDR_HIGH_DRV_EN, 4'h0);
		for (int i = 0; i < 6; i++) begin
			op(BIPC_OP_TEST, 4'(i), 4'h0);
			chk("test bit", 16'(bit_ext[i]), 16'(test_bit));
		end
		// Function select takes pins 0 and 4 over the drive enables
		wr(ADDR_LOW_DRV_EN, 4'hF);
		wr(ADDR_HIGH_DRV_EN, 4'h3);
		wr(ADDR_FUNC_SEL_B, 4'h9);
		chk("fsel oe", 16'h002E, 16'(bitport_oe));
		chk("stop pin lo", 16'h0000, 16'(stop_release_input));
		chk("irq pin hi", 16'h0001, 16'(external_irq_zero));
		bit_ext = 6'h10;
		tick();
		chk("stop pin hi", 16'h0001, 16'(stop_release_input));
		chk("irq pin lo", 16'h0000, 16'(external_irq_zero));
		wr(ADDR_FUNC_SEL_B, 4'h0);
		chk("fsel off oe", 16'h003F, 16'(bitport_oe));
		chk("stop pin idle", 16'h0001, 16'(stop_release_input));
		// Pull-ups follow latches under the global bit
		wr(ADDR_MISC_CTRL, 4'h8);
		chk("pullup on", 16'h003F, 16'(bitport_pullup));
		op(BIPC_OP_CLR, 4'h2, 4'h0);
		chk("pullup latch", 16'h003B, 16'(bitport_pullup));
		// Nibble store, serial output drive mode, open-drain port, nibble load
		wr(ADDR_NIB_DRV_EN0, 4'hF);
		op(BIPC_OP_STORE, 4'h0, 4'hA);
		chk("nib out", 16'h000A, nibble_out & 16'h000F);
		chk("nib oe", 16'h000F, nibble_oe & 16'h000F);
		wr(ADDR_MISC_CTRL, 4'h4);
		chk("so od low", 16'h000F, nibble_oe & 16'h000F);
		op(BIPC_OP_STORE, 4'h0, 4'hF);
		chk("so od float", 16'h000B, nibble_oe & 16'h000F);
		wr(ADDR_MISC_CTRL, 4'h0);
		chk("so cmos", 16'h000F, nibble_oe & 16'h000F);
		nibble_periph_sel = 16'h0001;
		tick();
		chk("nib periph oe", 16'h000E, nibble_oe & 16'h000F);
		nibble_periph_sel = 16'h0000;
		wr(ADDR_NIB_DRV_EN0 + 8'h01, 4'hF);
		op(BIPC_OP_STORE, 4'h1, 4'h5);
		chk("od oe", 16'h00A0, nibble_oe & 16'h00F0);
		chk("od low", 16'h0000, nibble_out & nibble_oe & 16'h00F0);
		wr(ADDR_NIB_DRV_EN0 + 8'h03, 4'hF);
		op(BIPC_OP_STORE, 4'h3, 4'h0);
		chk("nib 3-pin oe", 16'hE000, nibble_oe & 16'hF000);
		op(BIPC_OP_LOAD, 4'h2, 4'h0);
		chk("nib load", 16'h0006, 16'(port_rdata));
		// Standby holds, stop floats and resets
		wr(ADDR_MISC_CTRL, 4'h8);
		power_mode = BIPC_PWR_STANDBY;
		tick();
		tick();
		chk("stby halt", 16'h0001, 16'(internal_halt_n));
		chk("stby out", 16'h003B, 16'(bitport_out));
		chk("stby oe", 16'h003F, 16'(bitport_oe));
		power_mode = BIPC_PWR_STOP;
		tick();
		op(BIPC_OP_CLR, 4'h1, 4'h0);
		chk("stop halt", 16'h0000, 16'(internal_halt_n));
		chk("stop oe", 16'h0000, 16'(bitport_oe));
		chk("stop nib oe", 16'h0000, nibble_oe);
		chk("stop pullup", 16'h0000, 16'(bitport_pullup) | 16'(nibble_pullup != 16'h0));
		power_mode = BIPC_PWR_RUN;
		tick();
		chk("post stop oe", 16'h0000, 16'(bitport_oe));
		chk("post stop pullup", 16'h0000, 16'(bitport_pullup));
		wr(ADDR_LOW_DRV_EN, 4'hF);
		wr(ADDR_HIGH_DRV_EN, 4'h3);
		chk("post stop latch", 16'h003F, 16'(bitport_out));
		chk("post stop fsel", 16'h003F, 16'(bitport_oe));
		results();
	end
endmodule : testbench
